// ==== logic/pmr_port_regs.sv ====
`timescale 1ns/1ps
// Operation
// - Each pin level compares against its match bit: 0 expects low, 1 high.
// - Masked-off pins are ignored; mask-set pins take part in the comparison.
// - Latch writes update the output latch for digital-mode pins only.
// - Latch reads return live synchronised pin levels, with analog-mode pins as 0, not stored latch.
// - On digital-mode pins, latch 0 drives low; latch 1 drives high or floats when open-drain.
// - Latch sits at 0x80 on every page, with single-bit access.
// - Input-mode bit 0 selects analog, disabling digital input; 1 digital.
// - Mode and match registers decode only on page 0xF; input mode at 0xEC.
// - Output-mode bit 0 is open-drain, 1 is push-pull.
module pmr_port_regs #(
    parameter int PORT_WIDTH = 8
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire pmr_pkg::pmr_req_s     regReq,
    output logic      [7:0]            rdData,
    output logic                       rdHit,
    input  wire logic [PORT_WIDTH-1:0] pinIn,
    output logic      [PORT_WIDTH-1:0] pinOut,
    output logic      [PORT_WIDTH-1:0] pinOe_n,
    output logic      [PORT_WIDTH-1:0] analogSel,
    output logic                       portMismatch
);

    // Registers are byte wide, so only an eight-pin port can be served
    if (PORT_WIDTH != 8) begin : g_bad_width
        $error("PORT_WIDTH must be 8 to fit the byte-wide registers");
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] pinLatch_r;
    logic [7:0] matchMask_r;
    logic [7:0] outputMode_r;
    logic [7:0] inputMode_r;
    logic [7:0] matchValue_r;
    logic [7:0] pinLevel;
    logic [7:0] digitalLevel;
    logic       cfgPage;
    logic       hitLatch;
    logic       hitMask;
    logic       hitOutMode;
    logic       hitInMode;
    logic       hitMatch;
    logic [7:0] latchWrVal;
    logic [7:0] latchWrMask;

    // ----------------------------------------------------------------
    // Pin input path
    // ----------------------------------------------------------------
    pmr_pin_sync #(
        .WIDTH (PORT_WIDTH)
    ) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .asyncIn  (pinIn),
        .syncOut  (pinLevel)
    );

    // Analog pins read as zero; a mask-set analog pin compares as low
    assign digitalLevel = pinLevel & inputMode_r;
    assign analogSel    = ~inputMode_r;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    assign cfgPage    = (regReq.page == pmr_pkg::CONFIG_PAGE);
    assign hitLatch   = (regReq.addr == pmr_pkg::PORT_PIN_LATCH_ADDR);
    assign hitMask    = cfgPage && (regReq.addr == pmr_pkg::PORT_MATCH_MASK_ADDR);
    assign hitOutMode = cfgPage && (regReq.addr == pmr_pkg::PORT_OUTPUT_MODE_ADDR);
    assign hitInMode  = cfgPage && (regReq.addr == pmr_pkg::PORT_INPUT_MODE_ADDR);
    assign hitMatch   = cfgPage && (regReq.addr == pmr_pkg::PORT_MATCH_VALUE_ADDR);

    // Bit access touches one latch bit; byte access touches all
    always_comb begin
        latchWrMask = 8'hff;
        latchWrVal  = regReq.wrData;
        if (regReq.bitAccess) begin
            latchWrMask                = 8'h00;
            latchWrMask[regReq.bitSel] = 1'b1;
            latchWrVal                 = {8{regReq.bitData}};
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pinLatch_r <= pmr_pkg::PORT_PIN_LATCH_RST;
        end else if (regReq.wrEn && hitLatch) begin
            // Analog pins keep their latch value
            pinLatch_r <= (pinLatch_r & ~(latchWrMask & inputMode_r))
                        | (latchWrVal & latchWrMask & inputMode_r);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            matchMask_r  <= pmr_pkg::PORT_MATCH_MASK_RST;
            outputMode_r <= pmr_pkg::PORT_OUTPUT_MODE_RST;
            inputMode_r  <= pmr_pkg::PORT_INPUT_MODE_RST;
            matchValue_r <= pmr_pkg::PORT_MATCH_VALUE_RST;
        end else if (regReq.wrEn && !regReq.bitAccess) begin
            if (hitMask) begin
                matchMask_r <= regReq.wrData;
            end
            if (hitOutMode) begin
                outputMode_r <= regReq.wrData;
            end
            if (hitInMode) begin
                inputMode_r <= regReq.wrData;
            end
            if (hitMatch) begin
                matchValue_r <= regReq.wrData;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdData <= 8'h00;
            rdHit  <= 1'b0;
        end else begin
            rdHit  <= regReq.rdEn
                    && (hitLatch || hitMask || hitOutMode || hitInMode || hitMatch);
            rdData <= 8'h00;
            if (regReq.rdEn) begin
                unique case (1'b1)
                    hitLatch:   rdData <= digitalLevel;
                    hitMask:    rdData <= matchMask_r;
                    hitOutMode: rdData <= outputMode_r;
                    hitInMode:  rdData <= inputMode_r;
                    hitMatch:   rdData <= matchValue_r;
                    default:    rdData <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    // Enable is active low; open-drain high releases the pin
    assign pinOut  = pinLatch_r;
    assign pinOe_n = ~(~pinLatch_r | outputMode_r) | ~inputMode_r;

    // ----------------------------------------------------------------
    // Match comparison
    // ----------------------------------------------------------------
    // Registered so the flag is glitch free
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            portMismatch <= 1'b0;
        end else begin
            portMismatch <= |((digitalLevel ^ matchValue_r) & matchMask_r);
        end
    end

endmodule

// ==== shared/pmr_pkg.sv ====
package pmr_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] PORT_PIN_LATCH_ADDR   = 8'h80;
    localparam logic [7:0] PORT_MATCH_MASK_ADDR  = 8'h8b;
    localparam logic [7:0] PORT_OUTPUT_MODE_ADDR = 8'hd9;
    localparam logic [7:0] PORT_INPUT_MODE_ADDR  = 8'hec;
    localparam logic [7:0] PORT_MATCH_VALUE_ADDR = 8'hf4;
    localparam logic [3:0] CONFIG_PAGE           = 4'hf;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PORT_PIN_LATCH_RST   = 8'hff;
    localparam logic [7:0] PORT_MATCH_MASK_RST  = 8'h00;
    localparam logic [7:0] PORT_OUTPUT_MODE_RST = 8'h00;
    localparam logic [7:0] PORT_INPUT_MODE_RST  = 8'hff;
    localparam logic [7:0] PORT_MATCH_VALUE_RST = 8'hff;

    // ----------------------------------------------------------------
    // Register access request from the core
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic       bitAccess;
        logic [2:0] bitSel;
        logic       bitData;
        logic [3:0] page;
        logic [7:0] addr;
        logic [7:0] wrData;
    } pmr_req_s;

endpackage

// ==== logic/pmr_pin_sync.sv ====
`timescale 1ns/1ps
module pmr_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_r;

    // Stage one feeds only stage two
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stage1_r <= '0;
            syncOut  <= '0;
        end else begin
            stage1_r <= asyncIn;
            syncOut  <= stage1_r;
        end
    end

endmodule

// ==== sim/pmr_pin_model.sv ====
`timescale 1ns/1ps
module pmr_pin_model (
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOe_n,
    input  wire logic [7:0] extEn,
    input  wire logic [7:0] extVal,
    output logic      [7:0] pinLevel
);
    // ----------------------------------------
    // Pin wire: released pins pull up
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pinLevel[i] = !pinOe_n[i] ? pinOut[i] : (extEn[i] ? extVal[i] : 1'b1);
        end
    end
endmodule

// ==== sim/pmr_port_regs_chk.sv ====
`timescale 1ns/1ps
module pmr_port_regs_chk #(
    parameter int PORT_WIDTH = 8
) (
    input wire logic                  core_clk,
    input wire logic                  reset,
    input wire pmr_pkg::pmr_req_s     regReq,
    input wire logic [7:0]            rdData,
    input wire logic                  rdHit,
    input wire logic [PORT_WIDTH-1:0] pinIn,
    input wire logic [PORT_WIDTH-1:0] pinOut,
    input wire logic [PORT_WIDTH-1:0] pinOe_n,
    input wire logic [PORT_WIDTH-1:0] analogSel,
    input wire logic                  portMismatch
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_latch_read_hit: assert property (regReq.rdEn && regReq.addr == 8'h80 |=> rdHit)
        else $error("latch read missed");
    a_wrong_page_miss: assert property (regReq.rdEn && regReq.page != 4'hf &&
        regReq.addr == 8'hec |=> !rdHit && rdData == 8'h00) else $error("off page read hit");
    a_hit_needs_read: assert property (rdHit |-> $past(regReq.rdEn))
        else $error("hit without read");
    a_latch_write: assert property (regReq.wrEn && !regReq.bitAccess && regReq.addr == 8'h80
        |=> ((pinOut ^ $past(regReq.wrData)) & ~analogSel) == '0) else $error("latch write lost");
    a_analog_released: assert property ((analogSel & ~pinOe_n) == '0)
        else $error("analog pin driven");
    a_low_driven: assert property ((~pinOut & ~analogSel & pinOe_n) == '0)
        else $error("low latch not driven");
    a_mask_quiets: assert property (regReq.wrEn && regReq.page == 4'hf && regReq.addr == 8'h8b
        && regReq.wrData == 8'h00 |-> ##2 !portMismatch) else $error("masked mismatch");
    a_push_pull: assert property (regReq.wrEn && regReq.page == 4'hf && regReq.addr == 8'hd9
        |=> pinOe_n == (analogSel | (pinOut & ~$past(regReq.wrData)))) else $error("drive mode");
    c_mismatch: cover property (portMismatch);
    c_read_hit: cover property (rdHit);
    c_analog: cover property (|analogSel);
endmodule
bind pmr_port_regs pmr_port_regs_chk #(.PORT_WIDTH(PORT_WIDTH)) pmr_port_regs_chk_i (
    .core_clk(core_clk), .reset(reset), .regReq(regReq), .rdData(rdData), .rdHit(rdHit),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n), .analogSel(analogSel),
    .portMismatch(portMismatch));

// ==== sim/pmr_port_regs_tb.sv ====
`timescale 1ns/1ps
module pmr_port_regs_tb;
    logic              core_clk, reset, rdHit, portMismatch;
    pmr_pkg::pmr_req_s regReq;
    logic [7:0]        rdData, pinIn, pinOut, pinOe_n, analogSel, extEn, extVal;
    int                errors, checked;
    pmr_port_regs #(.PORT_WIDTH(8)) pmr_port_regs_i (.core_clk(core_clk), .reset(reset),
        .regReq(regReq), .rdData(rdData), .rdHit(rdHit), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe_n(pinOe_n), .analogSel(analogSel), .portMismatch(portMismatch));
    pmr_pin_model pmr_pin_model_i (.pinOut(pinOut), .pinOe_n(pinOe_n), .extEn(extEn),
        .extVal(extVal), .pinLevel(pinIn));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [3:0] pg, logic [7:0] a, logic [7:0] d, logic b = 0, logic [2:0] s = 0);
        @(posedge core_clk) #1;
        regReq = '{wrEn:1'b1, bitAccess:b, bitSel:s, bitData:d[0], page:pg, addr:a, wrData:d,
            default:'0};
        @(posedge core_clk) #1;
        regReq = '0;
    endtask
    // Idle edges first so pin changes clear the synchroniser
    task automatic rd(logic [3:0] pg, logic [7:0] a, logic [7:0] exp, logic hit = 1);
        repeat (3) @(posedge core_clk);
        #1;
        regReq = '{rdEn:1'b1, page:pg, addr:a, default:'0};
        @(posedge core_clk) #1;
        regReq = '0;
        chk("rdData", rdData, exp);
        chk("rdHit", {7'h0, rdHit}, {7'h0, hit});
    endtask
    task automatic stop_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        core_clk = 0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        errors++;
        stop_test();
    end
    initial begin
        {errors, checked} = '0;
        regReq = '0;
        {extEn, extVal} = '0;
        reset = 1;
        repeat (3) @(posedge core_clk);
        #1 reset = 0;
        chk("pinOut", pinOut, 8'hff);
        chk("pinOe_n", pinOe_n, 8'hff);
        chk("portMismatch", {7'h0, portMismatch}, 8'h00);
        rd(4'hf, 8'hd9, 8'h00);
        rd(4'hf, 8'hec, 8'hff);
        rd(4'hf, 8'hf4, 8'hff);
        rd(4'h0, 8'h80, 8'hff);
        $display("test reset values done");
        wr(4'h3, 8'h80, 8'h55);
        chk("pinOut", pinOut, 8'h55);
        chk("pinOe_n", pinOe_n, 8'h55);
        extEn = 8'h04;
        rd(4'h0, 8'h80, 8'h51);
        wr(4'h0, 8'hd9, 8'hff);
        chk("pinOe_n", pinOe_n, 8'h55);
        rd(4'h0, 8'hd9, 8'h00, 0);
        rd(4'hf, 8'h00, 8'h00, 0);
        wr(4'hf, 8'hd9, 8'hff);
        chk("pinOe_n", pinOe_n, 8'h00);
        rd(4'h0, 8'h80, 8'h55);
        extEn = 8'h00;
        $display("test drive modes done");
        wr(4'hf, 8'hec, 8'hfe);
        chk("analogSel", analogSel, 8'h01);
        wr(4'h0, 8'h80, 8'h00);
        chk("pinOut", pinOut, 8'h01);
        chk("pinOe_n", pinOe_n, 8'h01);
        rd(4'h0, 8'h80, 8'h00);
        wr(4'hf, 8'hec, 8'hff);
        wr(4'h0, 8'h80, 8'h01, 1, 3'h7);
        chk("pinOut", pinOut, 8'h81);
        $display("test analog and bit access done");
        wr(4'h0, 8'h80, 8'hff);
        wr(4'hf, 8'hd9, 8'h00);
        wr(4'hf, 8'hf4, 8'hfe);
        wr(4'hf, 8'h8b, 8'h0f);
        rd(4'hf, 8'hf4, 8'hfe);
        chk("portMismatch", {7'h0, portMismatch}, 8'h01);
        extEn = 8'h81;
        rd(4'h0, 8'h80, 8'h7e);
        chk("portMismatch", {7'h0, portMismatch}, 8'h00);
        wr(4'hf, 8'h8b, 8'h00);
        $display("test match done");
        stop_test();
    end
endmodule
